/* File: rtl/fcd_host.sv */
`timescale 1ns/1ps
module fcd_host #(
  parameter int ICLK_NS = fcd_pkg::ICLK_PERIOD_NS
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // command from the user side
  input wire logic start_i,
  input wire logic [3:0] tap_count_select_i,
  input wire logic [4:0] rate_bits_i,
  // coefficient stream, centre tap first
  input wire logic coef_valid_i,
  input wire fcd_pkg::fcd_coef_t coef_i,
  output logic coef_ready_o,
  // status to the user side
  output logic busy_o,
  output logic done_o,
  output logic download_ok_flag_o,
  output logic gain_exact_o,
  // parallel register bus of the converter
  output fcd_pkg::fcd_bus_out_t bus_o,
  input wire logic [15:0] bus_data_i
);
  import fcd_pkg::*;

  localparam int HALF_ICLK_DIV = 2 * CLK_PERIOD_NS;

  typedef struct packed {
    fcd_state_t st;
    logic [2:0] ph;
    logic [3:0] sel;
    logic [4:0] low;
    logic [5:0] n;
    logic [5:0] cnt;
    logic [15:0] wait_q;
    logic [15:0] csum;
    logic [31:0] gsum;
    fcd_coef_t coef;
    logic [15:0] s1;
    logic [15:0] s2;
    fcd_bus_out_t bus;
    logic busy;
    logic done;
    logic ok;
    logic gain;
  } fcd_host_state_t;

  fcd_host_state_t q;
  fcd_host_state_t d;
  logic buf_valid;
  logic buf_ready;
  logic [26:0] buf_data;
  fcd_coef_t c;
  logic [31:0] padded;
  logic sel_ok;
  logic [5:0] n_new;
  logic is_wr;
  logic is_bus;
  logic [2:0] last_ph;
  logic ph_end;

  // two-entry buffer decouples the user stream from bus pacing
  fcd_skid_buf #(
    .W(27),
    .DEPTH(2)
  ) u_buf (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .in_valid_i(coef_valid_i),
    .in_data_i(coef_i),
    .in_ready_o(coef_ready_o),
    .out_valid_o(buf_valid),
    .out_data_o(buf_data),
    .out_ready_i(buf_ready)
  );

  // wait after the checksum: half an internal clock per unused coefficient, rounded up
  function automatic logic [15:0] zero_ticks(input logic [5:0] n);
    int unused;
    int t;
    unused = int'(MAX_COEF) - int'(n);
    t = (unused * ICLK_NS + HALF_ICLK_DIV - 1) / HALF_ICLK_DIV;
    return 16'(t);
  endfunction : zero_ticks

  function automatic logic wr_state(input fcd_state_t s);
    return (s == S_WADDR) || (s == S_WCTRL) || (s == S_WHI) || (s == S_WLO)
        || (s == S_WSUM) || (s == S_WADDR2) || (s == S_WCTRL2);
  endfunction : wr_state

  // word driven in each write state
  function automatic logic [15:0] word_of(input fcd_host_state_t s);
    logic [15:0] w;
    w = RST_WORD;
    case (s.st)
      S_WADDR, S_WADDR2: w = ADDR_CR1;
      S_WCTRL: begin
        w[CR_TAP_COUNT_SELECT_LSB +: 4] = s.sel;
        w[CR_DL_BIT] = (s.sel != TAP_COUNT_SELECT_DEFAULT);
        w[4:0] = s.low;
      end
      S_WCTRL2: begin
        w[CR_TAP_COUNT_SELECT_LSB +: 4] = s.sel;
        w[CR_RDSTAT_BIT] = 1'b1;
        w[4:0] = s.low;
      end
      S_WHI: w = {{HI_PAD_W{1'b0}}, s.coef.sign, s.coef.mag[25:16]};
      S_WLO: w = s.coef.mag[15:0];
      S_WSUM: w = s.csum;
      default: w = RST_WORD;
    endcase
    return w;
  endfunction : word_of

  assign c = fcd_coef_t'(buf_data);
  assign padded = {{HI_PAD_W{1'b0}}, c.sign, c.mag};
  assign buf_ready = (q.st == S_FETCH);
  // only the default code or an odd code gives a legal half length
  assign sel_ok = (tap_count_select_i == TAP_COUNT_SELECT_DEFAULT) || tap_count_select_i[0];
  assign n_new = 6'(({2'b00, tap_count_select_i} + 6'h01) * 6'h03);
  assign is_wr = wr_state(q.st);
  assign is_bus = is_wr || (q.st == S_RSTAT);
  assign last_ph = (q.st == S_RSTAT) ? PH_RD_END : PH_WR_END;
  assign ph_end = is_bus && (q.ph == last_ph);

  // sequencer: one bus cycle per write or read state, advancing when its last phase ends
  always_comb begin
    d = q;
    d.done = 1'b0;
    d.s1 = bus_data_i;
    d.s2 = q.s1;
    if (is_bus) begin
      d.ph = ph_end ? 3'h0 : q.ph + 3'h1;
    end
    case (q.st)
      S_IDLE: begin
        if (start_i && sel_ok) begin
          d.sel = tap_count_select_i;
          d.low = rate_bits_i;
          d.n = n_new;
          d.cnt = 6'h00;
          d.csum = 16'h0000;
          d.gsum = 32'h00000000;
          d.ok = 1'b0;
          d.gain = 1'b0;
          d.ph = 3'h0;
          d.st = S_WADDR;
        end
      end
      S_WADDR: begin
        if (ph_end) begin
          d.st = S_WCTRL;
        end
      end
      S_WCTRL: begin
        // the default code needs no download; the device keeps its own set
        if (ph_end && q.sel == TAP_COUNT_SELECT_DEFAULT) begin
          d.st = S_IDLE;
          d.done = 1'b1;
        end else if (ph_end) begin
          d.st = S_FETCH;
        end
      end
      S_FETCH: begin
        // words go out in arrival order, so the user supplies centre first
        if (buf_valid) begin
          d.coef = c;
          d.csum = q.csum + 16'(padded[31:24]) + 16'(padded[23:16])
                 + 16'(padded[15:8]) + 16'(padded[7:0]);
          d.gsum = c.sign ? q.gsum - 32'(c.mag) : q.gsum + 32'(c.mag);
          d.ph = 3'h0;
          d.st = S_WHI;
        end
      end
      S_WHI: begin
        if (ph_end) begin
          d.st = S_WLO;
        end
      end
      S_WLO: begin
        if (ph_end) begin
          d.cnt = q.cnt + 6'h01;
          d.st = (q.cnt == q.n - 6'h01) ? S_WSUM : S_FETCH;
        end
      end
      S_WSUM: begin
        if (ph_end) begin
          d.gain = (q.gsum == SUM_TARGET);
          d.wait_q = zero_ticks(q.n);
          d.st = (zero_ticks(q.n) != 16'h0000) ? S_ZWAIT : S_WADDR2;
        end
      end
      S_ZWAIT: begin
        // device is filling unused taps with zeros; the bus stays idle
        d.wait_q = q.wait_q - 16'h0001;
        if (q.wait_q == 16'h0001) begin
          d.ph = 3'h0;
          d.st = S_WADDR2;
        end
      end
      S_WADDR2: begin
        if (ph_end) begin
          d.st = S_WCTRL2;
        end
      end
      S_WCTRL2: begin
        if (ph_end) begin
          d.st = S_RSTAT;
        end
      end
      S_RSTAT: begin
        // sample late in the strobe so the synchroniser has the settled word
        if (q.ph == PH_RD_SAMP) begin
          d.ok = q.s2[STAT_OK_BIT];
        end
        if (ph_end) begin
          d.st = S_IDLE;
          d.done = 1'b1;
        end
      end
      default: begin
        d.st = S_IDLE;
      end
    endcase
    // pins are computed from the next state so they leave a flop
    d.busy = (d.st != S_IDLE);
    d.bus.cs_n = !((wr_state(d.st) || d.st == S_RSTAT)
        && d.ph != ((d.st == S_RSTAT) ? PH_RD_END : PH_WR_END));
    d.bus.wr_n = !(wr_state(d.st) && d.ph >= PH_WR_ON && d.ph < PH_WR_OFF);
    d.bus.rd_n = !(d.st == S_RSTAT && d.ph >= 3'h1 && d.ph < PH_RD_END);
    d.bus.oe = wr_state(d.st) && d.ph != PH_WR_END;
    d.bus.data = word_of(d);
  end

  // reset forgets any earlier download, matching the device's volatile set
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '{st: S_IDLE, ph: 3'h0, sel: 4'h0, low: 5'h00, n: 6'h00,
             cnt: 6'h00, wait_q: 16'h0000, csum: 16'h0000,
             gsum: 32'h00000000, coef: '0, s1: 16'h0000, s2: 16'h0000,
             bus: '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, oe: 1'b0,
                    data: 16'h0000},
             busy: 1'b0, done: 1'b0, ok: 1'b0, gain: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign busy_o = q.busy;
  assign done_o = q.done;
  assign download_ok_flag_o = q.ok;
  assign gain_exact_o = q.gain;
  assign bus_o = q.bus;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence s_wr_strobe;
    !q.bus.wr_n [*2] ##1 q.bus.wr_n;
  endsequence

  sequence s_pair_done;
    (q.st == S_WLO && ph_end);
  endsequence

  // read strobe spans the four cycles the synchroniser needs
  sequence s_rd_strobe;
    !q.bus.rd_n [*4] ##1 q.bus.rd_n;
  endsequence

  AST_WR_STROBE: assert property ($fell(q.bus.wr_n) |-> s_wr_strobe)
    else $error("write strobe not two cycles low");
  AST_HI_THEN_LO: assert property ((q.st == S_WHI && ph_end) |=> q.st == S_WLO)
    else $error("high word not followed by low word");
  AST_HI_PAD: assert property ((q.st == S_WHI && !q.bus.wr_n) |->
      q.bus.data[15:11] == 5'h00 && q.bus.data[10] == q.coef.sign)
    else $error("high word padding or sign wrong");
  AST_SUM_AFTER_LAST: assert property (s_pair_done and (q.cnt == q.n - 6'h01)
      |=> q.st == S_WSUM && q.cnt == q.n)
    else $error("checksum not sent after last coefficient");
  AST_CTRL_WORD: assert property ((q.st == S_WCTRL && !q.bus.wr_n) |->
      q.bus.data[CR_TAP_COUNT_SELECT_LSB +: 4] == q.sel
      && q.bus.data[CR_DL_BIT] == (q.sel != TAP_COUNT_SELECT_DEFAULT))
    else $error("control word does not request download");
  AST_STAT_REQ: assert property ((q.st == S_WCTRL2 && !q.bus.wr_n) |->
      q.bus.data[CR_RDSTAT_BIT] && !q.bus.data[CR_DL_BIT])
    else $error("status request word wrong");
  AST_ZERO_WAIT: assert property ((q.st == S_WSUM && ph_end && q.n != MAX_COEF)
      |=> q.st == S_ZWAIT && q.wait_q == zero_ticks(q.n))
    else $error("unused-tap wait not started");
  AST_OK_CAPTURE: assert property ((q.st == S_RSTAT && q.ph == PH_RD_SAMP)
      |=> download_ok_flag_o == $past(q.s2[STAT_OK_BIT]))
    else $error("ok flag not taken from status bit");
  AST_SUM_BYTES: assert property ((q.st == S_FETCH && buf_valid) |=>
      q.csum == $past(q.csum) + 16'($past(padded[31:24]))
      + 16'($past(padded[23:16])) + 16'($past(padded[15:8]))
      + 16'($past(padded[7:0])))
    else $error("checksum byte sum wrong");
  AST_RD_STROBE: assert property ($fell(q.bus.rd_n) |-> s_rd_strobe)
    else $error("read strobe not four cycles low");
  AST_OE_ON_WRITE: assert property (!q.bus.wr_n |-> q.bus.oe && !q.bus.cs_n && q.bus.rd_n)
    else $error("write strobe without driven bus");
  AST_NO_CONTENTION: assert property (!q.bus.rd_n |-> !q.bus.oe)
    else $error("bus driven during status read");
  AST_DONE_IDLE: assert property (q.done |-> !q.busy && q.bus.cs_n)
    else $error("done while bus still busy");
endmodule : fcd_host

/* File: rtl/fcd_pkg.sv */
// Contract
// - A user filter is an even-length FIR with symmetric impulse response.
// - Coefficients are sign-magnitude: 26 magnitude bits, sign 0 positive, 1 negative.
// - User filter length is a multiple of 12, from 12 to 96 taps.
// - Only half the taps are sent; the device mirrors them.
// - Coefficients go from the symmetry point outward; stored in that order.
// - Signed half-response sum should be 0x3FFFFFF; otherwise gain error.
// - Coefficient padded to 32 bits, sent high word then low word.
// - One 16-bit checksum word follows the last coefficient's second word.
// - Checksum is 16-bit sum of all bytes of the padded words.
// - Download starts by writing control 1 with enable bit and length field.
// - Length code 0000 default; odd codes 1..15 select 6..48 coefficients.
// - Word pairs then checksum follow with no other writes between.
// - Host waits half an internal clock per unused coefficient after checksum.
// - Each register write is an address word then one data word; control 1 is 0x0001.
package fcd_pkg;
  localparam logic [15:0] ADDR_CR1 = 16'h0001;
  localparam int CR_DL_BIT = 15;
  localparam int CR_RDSTAT_BIT = 11;
  localparam int CR_TAP_COUNT_SELECT_LSB = 5;
  localparam int STAT_OK_BIT = 7;
  localparam int HI_PAD_W = 5;
  localparam int MAG_W = 26;
  localparam logic [5:0] MAX_COEF = 6'h30;
  localparam logic [3:0] TAP_COUNT_SELECT_DEFAULT = 4'h0;
  localparam logic [31:0] SUM_TARGET = 32'h03FFFFFF;
  localparam int CLK_PERIOD_NS = 100;
  localparam int ICLK_PERIOD_NS = 200;
  // bus cycle phases: write strobe low in [WR_ON, WR_OFF), chip select off at END
  localparam logic [2:0] PH_WR_ON = 3'h1;
  localparam logic [2:0] PH_WR_OFF = 3'h3;
  localparam logic [2:0] PH_WR_END = 3'h4;
  localparam logic [2:0] PH_RD_SAMP = 3'h4;
  localparam logic [2:0] PH_RD_END = 3'h5;
  localparam logic [15:0] RST_WORD = 16'h0000;

  typedef struct packed {
    logic sign;
    logic [MAG_W-1:0] mag;
  } fcd_coef_t;

  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic oe;
    logic [15:0] data;
  } fcd_bus_out_t;

  typedef enum logic [10:0] {
    S_IDLE   = 11'h001,
    S_WADDR  = 11'h002,
    S_WCTRL  = 11'h004,
    S_FETCH  = 11'h008,
    S_WHI    = 11'h010,
    S_WLO    = 11'h020,
    S_WSUM   = 11'h040,
    S_ZWAIT  = 11'h080,
    S_WADDR2 = 11'h100,
    S_WCTRL2 = 11'h200,
    S_RSTAT  = 11'h400
  } fcd_state_t;
endpackage : fcd_pkg

/* File: rtl/fcd_skid_buf.sv */
`timescale 1ns/1ps
module fcd_skid_buf #(
  parameter int W = 27,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic rdy;
    logic empty;
  } fcd_buf_state_t;

  fcd_buf_state_t q;
  fcd_buf_state_t d;
  logic push;
  logic pop;

  // ready and empty are flops so both handshakes come straight from registers
  always_comb begin
    d = q;
    push = in_valid_i && q.rdy;
    pop = out_ready_i && !q.empty;
    if (push) begin
      d.mem[q.wp] = in_data_i;
      d.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    d.rdy = (d.cnt != CNT_FULL);
    d.empty = (d.cnt == '0);
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '{mem: '0, wp: '0, rp: '0, cnt: '0, rdy: 1'b1, empty: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign in_ready_o = q.rdy;
  assign out_valid_o = !q.empty;
  assign out_data_o = q.mem[q.rp];
endmodule : fcd_skid_buf

/* File: tb/fcd_dev_model.sv */
`timescale 1ns/1ps
module fcd_dev_model #(
  parameter int ICLK_NS = fcd_pkg::ICLK_PERIOD_NS
) (
  // clock, reset and fault request
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic bad_sum_i,
  // parallel bus
  input wire fcd_pkg::fcd_bus_out_t bus_i,
  output logic [15:0] bus_data_o,
  // host broke the unused-tap wait
  output logic wait_err_o
);
  import fcd_pkg::*;
  localparam int TWO_CLK = 2 * CLK_PERIOD_NS;
  logic [26:0] ram_q [48];
  logic [15:0] sum_q;
  logic [15:0] hi_q;
  logic [7:0] cnt_q;
  logic [6:0] n_q;
  logic wr_q, cs_q, dl_q, addr_q, ok_q;
  int gap_q, need_q;

  // a word is taken at the rising write strobe; reset drops any user set
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 48; i++) ram_q[i] <= 27'(i + 1);
      {wr_q, cs_q, addr_q, dl_q, ok_q, wait_err_o} <= 6'h38;
      {sum_q, hi_q, cnt_q, n_q} <= '0;
      {gap_q, need_q} <= '0;
    end else begin
      {wr_q, cs_q} <= {bus_i.wr_n, bus_i.cs_n};
      gap_q <= gap_q + 1;
      if (!bus_i.cs_n && cs_q && gap_q < need_q) wait_err_o <= 1'b1;
      if (!bus_i.cs_n && bus_i.wr_n && !wr_q) begin
        if (dl_q && cnt_q == {n_q, 1'b0}) begin
          ok_q <= (bus_i.data == sum_q) && !bad_sum_i;
          dl_q <= 1'b0;
          gap_q <= 0;
          need_q <= ((48 - int'(n_q)) * ICLK_NS + TWO_CLK - 1) / TWO_CLK;
          for (int i = 0; i < 48; i++) if (i >= int'(n_q)) ram_q[i] <= '0;
        end else if (dl_q) begin
          cnt_q <= cnt_q + 8'h01;
          sum_q <= sum_q + 16'(bus_i.data[15:8]) + 16'(bus_i.data[7:0]);
          hi_q <= bus_i.data;
          if (cnt_q[0]) ram_q[cnt_q[6:1]] <= {hi_q[10:0], bus_i.data};
        end else if (addr_q) begin
          addr_q <= (bus_i.data != ADDR_CR1);
        end else begin
          addr_q <= 1'b1;
          if (bus_i.data[CR_DL_BIT] && bus_i.data[8:5] != 4'h0) begin
            {dl_q, ok_q, cnt_q, sum_q} <= {2'h2, 24'h0};
            n_q <= 7'(3 * (int'(bus_i.data[8:5]) + 1));
          end
        end
      end
    end
  end

  // a released bus shows a moving pattern, never the last word
  assign bus_data_o = (!bus_i.cs_n && !bus_i.rd_n) ? {8'h00, ok_q, 7'h00}
      : {16{gap_q[0]}};
endmodule : fcd_dev_model

/* File: tb/fcd_host_test.sv */
`timescale 1ns/1ps
module fcd_host_test;
  import fcd_pkg::*;
  localparam logic [31:0] EX [12] = '{32'h032B9688, 32'h01BF183C, 32'h00156626, 32'h04A81E6A,
    32'h045F2A96, 32'h002C49C2, 32'h0050E9F6, 32'h0010DBD8, 32'h042FDE54, 32'h0437445A,
    32'h041B7D6E, 32'h04043B5F};
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic start_i = 1'b0;
  logic coef_valid_i = 1'b0;
  logic bad_sum = 1'b0;
  logic [3:0] tap_count_select_i = 4'h0;
  logic [4:0] rate_bits_i = 5'h00;
  fcd_coef_t coef_i = '0;
  logic coef_ready_o, busy_o, done_o, download_ok_flag_o, gain_exact_o, wait_err;
  fcd_bus_out_t bus_o;
  logic [15:0] bus_data_i;
  logic [31:0] exp_q [$];
  logic [31:0] res_q [$];
  logic [31:0] seed = 32'h8B5909AB;
  logic mon_wr_q = 1'b1;
  fcd_coef_t cf [48];
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;

  fcd_host dut (.core_clk_i, .nrst_i, .start_i, .tap_count_select_i, .rate_bits_i,
    .coef_valid_i, .coef_i, .coef_ready_o, .busy_o, .done_o, .download_ok_flag_o,
    .gain_exact_o, .bus_o, .bus_data_i);
  fcd_dev_model dev (.core_clk_i, .nrst_i, .bad_sum_i(bad_sum), .bus_i(bus_o),
    .bus_data_o(bus_data_i), .wait_err_o(wait_err));

  // 10 MHz clock
  always #50 core_clk_i = ~core_clk_i;

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [31:0] pins();
    return {26'h0, bus_o.cs_n, bus_o.wr_n, bus_o.rd_n, bus_o.oe, busy_o, coef_ready_o};
  endfunction : pins

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // leftover notes count as misses too
  task automatic final_report();
    num_errors += exp_q.size() + res_q.size();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  task automatic tick(int k);
    repeat (k) @(posedge core_clk_i);
    #1;
  endtask : tick

  // hold the word until an edge finds ready high
  task automatic push(fcd_coef_t c);
    coef_i = c;
    coef_valid_i = 1'b1;
    do @(posedge core_clk_i); while (coef_ready_o !== 1'b1);
    #1;
  endtask : push

  // every write strobe and done pulse is matched against the oldest note
  always @(posedge core_clk_i) begin
    cyc = cyc + 1;
    mon_wr_q <= bus_o.wr_n;
    if (bus_o.cs_n === 1'b0 && bus_o.wr_n === 1'b1 && mon_wr_q === 1'b0) begin
      check("bus word", {16'h0, bus_o.data}, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
      check("bus drive", 32'(bus_o.oe), 32'h1);
    end
    if (done_o === 1'b1)
      check("ok and gain", {30'h0, download_ok_flag_o, gain_exact_o},
        res_q.size() > 0 ? res_q.pop_front() : 'x);
    if (cyc == 40000) begin
      num_errors++;
      final_report();
    end
  end

  // one command: note every bus word and flag pair, then feed the stream
  task automatic run(logic [3:0] code, bit example, bit corrupt, int abort);
    int n;
    logic [15:0] sum;
    logic [31:0] w;
    logic [31:0] acc;
    logic [4:0] r;
    n = (code == 4'h0) ? 0 : 3 * (int'(code) + 1);
    sum = 16'h0000;
    acc = 32'h0;
    seed = lfsr(seed);
    r = seed[4:0];
    rate_bits_i = r;
    bad_sum = corrupt;
    exp_q.push_back(32'(ADDR_CR1));
    exp_q.push_back({16'h0, code != 4'h0, 6'h00, code, r});
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      w = example ? EX[i] : {5'h00, seed[26:0]};
      cf[i] = w[26:0];
      exp_q.push_back({16'h0, w[31:16]});
      exp_q.push_back({16'h0, w[15:0]});
      sum += 16'(w[31:24]) + 16'(w[23:16]) + 16'(w[15:8]) + 16'(w[7:0]);
      acc += w[26] ? -32'(w[25:0]) : 32'(w[25:0]);
    end
    if (example) begin
      check("example checksum", 32'(sum), 32'h00000E6B);
      check("example gain sum", acc, SUM_TARGET);
    end
    if (n > 0) begin
      exp_q.push_back({16'h0, sum});
      exp_q.push_back(32'(ADDR_CR1));
      exp_q.push_back({16'h0, 5'h01, 2'h0, code, r});
    end
    res_q.push_back({30'h0, n > 0 && !corrupt, n > 0 && acc == SUM_TARGET});
    for (int i = 0; i < 2 && i < n; i++) push(cf[i]);
    coef_valid_i = 1'b0;
    if (n > 0) check("buffer full", 32'(coef_ready_o), 32'h0);
    tap_count_select_i = code;
    start_i = 1'b1;
    tick(1);
    start_i = 1'b0;
    tap_count_select_i = ~code; // a start while busy must be ignored
    tick(1);
    start_i = 1'b1;
    tick(1);
    start_i = 1'b0;
    if (abort > 0) begin
      tick(abort);
      nrst_i = 1'b0;
      tick(2);
      check("pins in reset", pins(), 32'h39);
      exp_q.delete();
      res_q.delete();
      nrst_i = 1'b1;
      $display("test done, reset during code %h", code);
      return;
    end
    for (int i = 2; i < n; i++) begin
      seed = lfsr(seed);
      if (seed[0]) begin
        coef_valid_i = 1'b0;
        tick(1);
      end
      push(cf[i]);
    end
    coef_valid_i = 1'b0;
    for (int k = 0; k < 4000 && done_o !== 1'b1; k++) tick(1);
    tick(1);
    check("unused-tap wait", 32'(wait_err), 32'h0);
    for (int i = 0; i < 48; i++)
      check("stored coefficient", 32'(dev.ram_q[i]),
        n == 0 ? 32'(i + 1) : i < n ? 32'(cf[i]) : 32'h0);
    $display("test done, code %h", code);
  endtask : run

  // main sequence
  initial begin
    tick(12);
    check("pins in reset", pins(), 32'h39);
    nrst_i = 1'b1;
    run(4'h0, 1'b0, 1'b0, 0);
    run(4'h3, 1'b1, 1'b0, 0);
    for (int c = 1; c < 16; c += 2) run(4'(c), 1'b0, 1'b0, 0);
    run(4'h5, 1'b0, 1'b1, 0);
    tap_count_select_i = 4'h6;
    start_i = 1'b1;
    tick(1);
    start_i = 1'b0;
    tick(3);
    check("busy after even code", 32'(busy_o), 32'h0);
    $display("test done, even code refused");
    run(4'hF, 1'b0, 1'b0, 40);
    run(4'h0, 1'b0, 1'b0, 0);
    final_report();
  end
endmodule : fcd_host_test
